/* File: shared/lpm_pkg.sv */
// Purpose: shared constants and types for the indicator pin multiplexer
// Assumes: one core clock, synchronous active high reset
// Notes: register map is a small apb window of our own
package lpm_pkg;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [11:0] LPM_WAKE_CTRL_OFF = 12'h000;
  localparam logic [11:0] LPM_STRAP_STAT_OFF = 12'h004;
  localparam logic [11:0] LPM_PIN_STAT_OFF = 12'h008;

  // ==========================================================
  // field positions in the wake control/status register
  localparam int LPM_LAMP1_SEL_POS = 0;
  localparam int LPM_LAMP2_SEL_POS = 2;
  localparam int LPM_WAKE_PIN_POS = 4;

  // ==========================================================
  // reset values
  localparam logic [5:0] LPM_WAKE_CTRL_RST = 6'h00;

  // ==========================================================
  // cycles from reset release to the strap sample
  localparam int LPM_STRAP_SETTLE_CYC = 2;

  // function select of one indicator pin
  typedef enum logic [1:0] {
    LPM_FN_ACTIVITY = 2'h0,
    LPM_FN_SPEED = 2'h1,
    LPM_FN_IRQ = 2'h2,
    LPM_FN_WAKE = 2'h3
  } lpm_fn_e;

  // where the wake event is also sent besides lamps
  typedef enum logic [1:0] {
    LPM_WAKE_NONE = 2'h0,
    LPM_WAKE_RXD2 = 2'h1
  } lpm_wake_e;

  // strap sampler state
  typedef enum logic [1:0] {
    LPM_ST_WAIT = 2'h0,
    LPM_ST_SAMPLE = 2'h1,
    LPM_ST_HELD = 2'h3
  } lpm_strap_st_e;

  // apb request bundle
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } lpm_apb_req_s;

  // status sources from the core
  typedef struct packed {
    logic activity;
    logic speed;
    logic irq_pend;
    logic wake_evt;
  } lpm_src_s;

endpackage

/* File: design/lpm_strap_latch.sv */
// Purpose: synchronise and hold the interrupt pin select strap
// Assumes: strap pin is asynchronous to mclk
// Notes: value is frozen until the next system reset
`timescale 1ns/1ns
module lpm_strap_latch
  import lpm_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic strap_pin,
  output logic strap_held_q,
  output logic strap_valid_q
);

  // ==========================================================
  // two-stage synchroniser
  logic sync1_q; // first stage, read only by the second
  logic sync2_q; // safe copy
  logic [1:0] cnt_q; // settle counter
  lpm_strap_st_e st_q;

  // synchroniser flops, reset to the pulled-up default
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= strap_pin;
      sync2_q <= sync1_q;
    end
  end

  // ==========================================================
  // sample once after release, then hold
  // sample then hold
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q <= LPM_ST_WAIT;
      cnt_q <= 2'h0;
      strap_held_q <= 1'b1;
      strap_valid_q <= 1'b0;
    end else begin
      case (st_q)
        LPM_ST_WAIT: begin
          // wait until the synchroniser carries the post-reset level
          if (cnt_q == 2'(LPM_STRAP_SETTLE_CYC - 1)) begin
            st_q <= LPM_ST_SAMPLE;
          end
          cnt_q <= cnt_q + 2'h1;
        end
        LPM_ST_SAMPLE: begin
          strap_held_q <= sync2_q;
          strap_valid_q <= 1'b1;
          st_q <= LPM_ST_HELD;
        end
        LPM_ST_HELD: begin
          st_q <= LPM_ST_HELD;
        end
        default: begin
          st_q <= LPM_ST_WAIT;
        end
      endcase
    end
  end

endmodule

/* File: design/lpm_pin_mux.sv */
// Purpose: output function multiplexer for two lamps and the shared irq pin
// Assumes: apb slave on mclk, sources synchronous to mclk
// Notes: strap pin is sampled after every system reset
//
// Notes on behaviour
// - lamp one function from its select field
// - lamp two function from its own field
// - interrupt output low while pending
// - interrupt defaults to the shared pin
// - interrupt may go to either lamp
// - wake event output low when signalled
// - wake event to lamp one, two, rxd2
// - strap high or floating gives interrupt
// - strap low gives tx error/symbol bit
// - straps sampled and held every reset
`timescale 1ns/1ns
module lpm_pin_mux
  import lpm_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // status sources from the core
  input wire logic link_activity,
  input wire logic link_speed,
  input wire logic irq_pending,
  input wire logic wake_event,
  // transmit error / symbol bit from the mac side
  input wire logic tx_err_mac,
  input wire logic tx_symbol_bit_four,
  input wire logic symbol_mode,
  // receive data bit 2 from the receive path
  input wire logic rxd2_data,
  // strap pin (asynchronous)
  input wire logic irq_pin_select_strap,
  // pins
  output logic status_lamp_one,
  output logic status_lamp_two,
  output logic irq_out_low,
  output logic irq_shared_oe,
  output logic rxd2_pin,
  output logic tx_err_core,
  output logic tx_sym4_core
);

  // ==========================================================
  // declarations
  lpm_apb_req_s req; // bundled bus request
  lpm_src_s src; // bundled status sources
  logic [5:0] wake_ctrl_status_reg_q; // software selects
  logic [1:0] fn_sel [2]; // per-lamp selects
  logic [1:0] lamp_d; // next lamp levels
  logic [1:0] lamp_q; // registered lamp levels
  logic strap_held; // held strap level
  logic strap_valid; // strap has been sampled
  logic irq_n; // active-low interrupt
  logic wake_n; // active-low wake event
  logic [31:0] rdata_d; // next read data
  logic hit; // address decodes
  logic acc; // access phase
  logic tx_err_d; // next tx error into core
  logic tx_sym4_d; // next symbol bit into core

  assign req = '{psel: psel, penable: penable, pwrite: pwrite,
                 paddr: paddr, pwdata: pwdata};
  assign src = '{activity: link_activity, speed: link_speed,
                 irq_pend: irq_pending, wake_evt: wake_event};

  // ==========================================================
  // strap sampler
  lpm_strap_latch u_strap (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .strap_pin(irq_pin_select_strap),
    .strap_held_q(strap_held),
    .strap_valid_q(strap_valid)
  );

  // ==========================================================
  // active-low event levels
  // low while pending
  assign irq_n = ~src.irq_pend;
  assign wake_n = ~src.wake_evt;

  // ==========================================================
  // apb slave; one wait state, pready is a flop set after the first access cycle
  assign acc = req.psel & req.penable;
  assign hit = (req.paddr == LPM_WAKE_CTRL_OFF) ||
               (req.paddr == LPM_STRAP_STAT_OFF) ||
               (req.paddr == LPM_PIN_STAT_OFF);

  // control register write, low byte lane only carries fields
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wake_ctrl_status_reg_q <= LPM_WAKE_CTRL_RST;
    end else if (acc && pready && req.pwrite && pstrb[0] &&
                 req.paddr == LPM_WAKE_CTRL_OFF) begin
      wake_ctrl_status_reg_q <= req.pwdata[5:0];
    end
  end

  // read data mux; unmapped offsets read zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (req.paddr)
      LPM_WAKE_CTRL_OFF: begin
        rdata_d[5:0] = wake_ctrl_status_reg_q;
      end
      LPM_STRAP_STAT_OFF: begin
        rdata_d[0] = strap_held;
        rdata_d[1] = strap_valid;
      end
      LPM_PIN_STAT_OFF: begin
        rdata_d[0] = lamp_q[0];
        rdata_d[1] = lamp_q[1];
        rdata_d[2] = irq_out_low;
        rdata_d[3] = irq_shared_oe;
        rdata_d[4] = rxd2_pin;
      end
      default: begin
        rdata_d = 32'h0000_0000;
      end
    endcase
  end

  // one wait state: setup, access, then pready in the next cycle
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (acc && !pready) begin
      pready <= 1'b1;
      pslverr <= ~hit;
      prdata <= req.pwrite ? 32'h0000_0000 : rdata_d;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // lamp multiplexer, one slice per lamp
  assign fn_sel[0] = wake_ctrl_status_reg_q[LPM_LAMP1_SEL_POS +: 2];
  assign fn_sel[1] = wake_ctrl_status_reg_q[LPM_LAMP2_SEL_POS +: 2];

  for (genvar i = 0; i < 2; i++) begin : g_lamp
    // per lamp select (lamp one is slice 0)
    always_comb begin
      case (lpm_fn_e'(fn_sel[i]))
        LPM_FN_ACTIVITY: lamp_d[i] = src.activity;
        LPM_FN_SPEED: lamp_d[i] = src.speed;
        LPM_FN_IRQ: lamp_d[i] = irq_n;
        LPM_FN_WAKE: lamp_d[i] = wake_n;
        default: lamp_d[i] = 1'b1;
      endcase
    end
  end

  // lamps registered so pins never glitch on select changes
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      lamp_q <= 2'h0;
    end else begin
      lamp_q <= lamp_d;
    end
  end
  assign status_lamp_one = lamp_q[0];
  assign status_lamp_two = lamp_q[1];

  // ==========================================================
  // shared interrupt / tx error pin
  // until the strap is known the pin stays released; driving it
  // early could fight a mac that is pulling it low as a tx error
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_out_low <= 1'b1;
      irq_shared_oe <= 1'b0;
    end else begin
      irq_out_low <= irq_n;
      irq_shared_oe <= strap_valid & strap_held;
    end
  end

  // tx error path into the core, gated off in interrupt mode
  always_comb begin
    tx_err_d = 1'b0;
    tx_sym4_d = 1'b0;
    if (strap_valid && !strap_held) begin
      if (symbol_mode) begin
        tx_sym4_d = tx_symbol_bit_four;
      end else begin
        tx_err_d = tx_err_mac;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tx_err_core <= 1'b0;
      tx_sym4_core <= 1'b0;
    end else begin
      tx_err_core <= tx_err_d;
      tx_sym4_core <= tx_sym4_d;
    end
  end

  // ==========================================================
  // receive data bit 2 pin, optionally carrying the wake event
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rxd2_pin <= 1'b0;
    end else begin
      if (lpm_wake_e'(wake_ctrl_status_reg_q[LPM_WAKE_PIN_POS +: 2]) ==
          LPM_WAKE_RXD2) begin
        rxd2_pin <= wake_n;
      end else begin
        rxd2_pin <= rxd2_data;
      end
    end
  end

endmodule

/* File: verif/lpm_pin_mux_assertions.sv */
// Purpose: port level checks of the indicator pin multiplexer
// Assumes: one clock domain, sync active high reset
// Notes: control field is shadowed from observed apb writes
`timescale 1ns/1ns
module lpm_pin_mux_chk
  import lpm_pkg::*;
(
  input logic mclk,
  input logic sys_rst,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [3:0] pstrb,
  input logic pready,
  input logic pslverr,
  input logic link_activity,
  input logic link_speed,
  input logic irq_pending,
  input logic wake_event,
  input logic rxd2_data,
  input logic tx_err_mac,
  input logic tx_symbol_bit_four,
  input logic symbol_mode,
  input logic irq_pin_select_strap,
  input logic status_lamp_one,
  input logic status_lamp_two,
  input logic irq_out_low,
  input logic irq_shared_oe,
  input logic rxd2_pin,
  input logic tx_err_core,
  input logic tx_sym4_core
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // helper state
  logic [5:0] ctl_q; // shadow of the control word
  logic [2:0] cnt_q; // edges since reset release, saturating
  logic cap_q; // strap level seen at the sampling edge
  lpm_src_s src;
  assign src = {link_activity, link_speed, irq_pending, wake_event};
  // shadow follows the write edge, the same edge the slave uses
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctl_q <= LPM_WAKE_CTRL_RST;
    end else if (psel && penable && pready && pwrite && pstrb[0] &&
                 paddr == LPM_WAKE_CTRL_OFF) begin
      ctl_q <= pwdata[5:0];
    end
  end
  // counter saturates so the sample edge is seen once per reset
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt_q <= 3'h0;
    end else if (cnt_q != 3'h7) begin
      cnt_q <= cnt_q + 3'h1;
    end
  end
  // capture the strap at the third edge after release
  always_ff @(posedge mclk) begin
    if (!sys_rst && cnt_q == 3'h2) begin
      cap_q <= irq_pin_select_strap;
    end
  end
  // lamp level from a select code
  function automatic logic fsel(input logic [1:0] s, input lpm_src_s v);
    case (s)
      LPM_FN_ACTIVITY: fsel = v.activity;
      LPM_FN_SPEED: fsel = v.speed;
      LPM_FN_IRQ: fsel = !v.irq_pend;
      default: fsel = !v.wake_evt;
    endcase
  endfunction
  // ==========================================================
  // assertions
  sequence acc_s;
    psel && penable && !pready;
  endsequence
  sequence ans_s;
    pready ##1 !pready;
  endsequence
  chk_apb_answer: assert property (acc_s |=> ans_s)
    else $error("answer pulse missing after access");
  chk_err_pulse: assert property (pslverr |-> pready)
    else $error("error flag outside the answer");
  chk_lamp_one: assert property (
    !$past(sys_rst) |-> status_lamp_one == fsel($past(ctl_q[1:0]), $past(src)))
    else $error("lamp one level wrong");
  chk_lamp_two: assert property (
    !$past(sys_rst) |-> status_lamp_two == fsel($past(ctl_q[3:2]), $past(src)))
    else $error("lamp two level wrong");
  chk_irq_low: assert property (
    !$past(sys_rst) |-> irq_out_low == !$past(irq_pending))
    else $error("interrupt level wrong");
  chk_wake_rxd2: assert property (!$past(sys_rst) |-> rxd2_pin ==
    ($past(ctl_q[5:4]) == 2'h1 ? !$past(wake_event) : $past(rxd2_data)))
    else $error("receive bit pin wrong");
  chk_strap_oe: assert property (cnt_q >= 3'h4 |-> irq_shared_oe == cap_q)
    else $error("shared pin mode wrong");
  chk_tx_gate: assert property (
    cnt_q >= 3'h4 && cap_q |-> !tx_err_core && !tx_sym4_core)
    else $error("transmit bits leak in interrupt mode");
  chk_tx_pass: assert property (
    cnt_q >= 3'h4 && !cap_q |->
    tx_err_core == ($past(tx_err_mac) && !$past(symbol_mode)) &&
    tx_sym4_core == ($past(tx_symbol_bit_four) && $past(symbol_mode)))
    else $error("transmit bits not passed in strap low mode");
  chk_strap_hold: assert property (cnt_q == 3'h7 |-> $stable(irq_shared_oe))
    else $error("held strap changed");
endmodule

/* File: verif/lpm_board_model.sv */
// Purpose: board resistors on the interrupt pin select strap
// Assumes: cfg 0 pull-down, 1 pull-up, other values floating
// Notes: floating is read through the internal pull-up
`timescale 1ns/1ns
module lpm_board_model (
  input logic [1:0] strap_cfg,
  output logic strap_pin
);
  // pulled low reads 0, pulled up or floating reads 1
  assign strap_pin = (strap_cfg != 2'h0);
endmodule

/* File: verif/lpm_testbench.sv */
// Purpose: self-checking bench for the indicator pin multiplexer
// Assumes: apb answers follow the hand-over timing
// Notes: every transfer pushes an expectation, a monitor pops them
`timescale 1ns/1ns
module testbench;
  import lpm_pkg::*;
  logic mclk = 0, sys_rst, psel, penable, pwrite, rxd, strap, lvl;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] pstrb;
  logic [2:0] txi; // transmit error, symbol bit, symbol mode
  logic [1:0] strap_cfg, w;
  logic pready, pslverr, l1, l2, irq_low, oe, rxp, txe, txs;
  logic [33:0] e; // {write, error, data}
  logic [33:0] exq[$];
  lpm_src_s src, v;
  int n_fail = 0, comparisons = 0;
  always #20 mclk = ~mclk;
  lpm_board_model board (.strap_cfg(strap_cfg), .strap_pin(strap));
  lpm_pin_mux DUT (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_activity(src.activity), .link_speed(src.speed),
    .irq_pending(src.irq_pend), .wake_event(src.wake_evt),
    .tx_err_mac(txi[2]), .tx_symbol_bit_four(txi[1]),
    .symbol_mode(txi[0]), .rxd2_data(rxd), .irq_pin_select_strap(strap),
    .status_lamp_one(l1), .status_lamp_two(l2), .irq_out_low(irq_low),
    .irq_shared_oe(oe), .rxd2_pin(rxp), .tx_err_core(txe),
    .tx_sym4_core(txs));
  // ==========================================================
  // shared tasks
  task automatic cmp(input logic [31:0] g, input logic [31:0] x,
                     input string m);
    comparisons++;
    if (g !== x) begin
      n_fail++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask
  task finish_test;
    $display("checks %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // one apb transfer; the request holds until pready is seen
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d, input logic [3:0] s, input logic [31:0] x);
    exq.push_back({wr, !(a == 12'h000 || a == 12'h004 || a == 12'h008), x});
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task reset_dut(input logic [1:0] c);
    @(posedge mclk);
    strap_cfg <= c;
    sys_rst <= 1'b1;
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask
  function automatic logic fn(input logic [1:0] s, input lpm_src_s q);
    fn = s == 2'h0 ? q.activity : s == 2'h1 ? q.speed :
         s == 2'h2 ? !q.irq_pend : !q.wake_evt;
  endfunction
  // monitor: each answer is matched to the oldest note
  always @(posedge mclk) begin
    if (pready === 1'b1) begin
      if (exq.size() == 0) cmp(32'h1, 32'h0, "answer without request");
      else begin
        e = exq.pop_front();
        cmp(pslverr, e[32], "slave error flag");
        if (!e[33]) cmp(prdata, e[31:0], "read data");
      end
    end
  end
  // watchdog far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    finish_test;
  end
  // ==========================================================
  // main sequence
  initial begin
    sys_rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0;
    pwdata = 0; pstrb = 0; src = '0; txi = 0; rxd = 0; strap_cfg = 0;
    r = $urandom(32'hB25B);
    // strap low, high, floating; later strap moves are ignored
    for (int c = 0; c < 3; c++) begin
      reset_dut(c[1:0]);
      lvl = (c != 0);
      cmp(oe, lvl, "shared pin mode");
      // random transmit inputs, passed only when the strap read low
      r = $urandom;
      txi <= r[2:0];
      repeat (2) @(posedge mclk);
      cmp(txe, !lvl && r[2] && !r[0], "tx error into core");
      cmp(txs, !lvl && r[1] && r[0], "symbol bit into core");
      apb(0, LPM_STRAP_STAT_OFF, 0, 0, {30'h0, 1'b1, lvl});
      strap_cfg <= lvl ? 2'h0 : 2'h1;
      apb(0, LPM_STRAP_STAT_OFF, 0, 0, {30'h0, 1'b1, lvl});
    end
    $display("strap test done");
    // every lamp function on both lamps, random sources
    for (int i = 0; i < 16; i++) begin
      w = $urandom_range(3);
      v = lpm_src_s'($urandom);
      r = $urandom;
      apb(1, LPM_WAKE_CTRL_OFF, {26'h0, w, i[3:0]}, 4'h1, 0);
      src <= v;
      rxd <= r[0];
      txi <= r[3:1];
      apb(0, LPM_WAKE_CTRL_OFF, 0, 0, {26'h0, w, i[3:0]});
      apb(0, LPM_PIN_STAT_OFF, 0, 0, {27'h0,
        w == 2'h1 ? !v.wake_evt : r[0], 1'b1, !v.irq_pend,
        fn(i[3:2], v), fn(i[1:0], v)});
      cmp(irq_low, !v.irq_pend, "interrupt on shared pin");
    end
    $display("lamp test done");
    // strobe off and unmapped places are refused
    apb(1, LPM_WAKE_CTRL_OFF, 32'h3F, 4'hE, 0);
    apb(0, LPM_WAKE_CTRL_OFF, 0, 0, {26'h0, w, 4'hF});
    apb(1, 12'h00C, 32'hFFFFFFFF, 4'hF, 0);
    apb(0, 12'h00C, 0, 0, 0);
    repeat (2) @(posedge mclk);
    $display("refusal test done");
    finish_test;
  end
endmodule
bind lpm_pin_mux lpm_pin_mux_chk chk_i (.*);
